// File: kpg_pkg.sv
package kpg_pkg;
   // ****************************************************************
   // Frame bytes and result codes
   // ****************************************************************
   localparam logic [7:0] CMD_START = 8'h66;
   localparam logic [7:0] LEN_CMD = 8'h02;
   localparam logic [7:0] OPC_KEYGEN = 8'hCB;
   localparam logic [7:0] RELEASE_BYTE = 8'hAA;
   localparam logic [7:0] DUMMY_BYTE = 8'hFF;
   localparam logic [7:0] LEN_RESP = 8'h01;
   localparam logic [7:0] RES_LOCKED = 8'h55;
   localparam logic [7:0] RES_BAD_ECC = 8'h22;
   localparam logic [7:0] RES_DISABLED = 8'h88;
   localparam logic [7:0] RES_OK = 8'hAA;
   localparam logic [7:0] PARAM_RST = 8'h00;

   // ****************************************************************
   // Parameter byte fields
   // ****************************************************************
   localparam int LOCK_MSB = 7;
   localparam int LOCK_LSB = 6;
   localparam int SRC_BIT = 0;

   // ****************************************************************
   // CRC-16, reflected form, shifted out low byte first
   // ****************************************************************
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_INIT = 16'h0000;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int KEY_GEN_TIME_NS = 2000;
   localparam int WRITE_TIME_NS = 1000;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] KGEN_CYC =
      CNT_W'((KEY_GEN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] WR_CYC =
      CNT_W'((WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LEN, ST_OPC, ST_PAR, ST_CRC0, ST_CRC1, ST_REL,
      ST_WAIT, ST_DUM, ST_RLEN, ST_RES, ST_RCRC0, ST_RCRC1
   } kpg_state_t;
endpackage

// File: kpg_crc_if.sv
`timescale 1ns/1ps
interface kpg_crc_if;
   logic clr;
   logic feed;
   logic [7:0] data;
   logic [15:0] crc;
   logic [15:0] crc_nxt;
   modport user (output clr, output feed, output data, input crc, input crc_nxt);
   modport engine (input clr, input feed, input data, output crc, output crc_nxt);
endinterface

// File: kpg_crc16.sv
`timescale 1ns/1ps
module kpg_crc16 (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Checksum carrier
   kpg_crc_if.engine crc_if
);
   logic [15:0] crc_r;
   logic [15:0] base;
   logic [15:0] stage [0:8];

   assign base = crc_if.clr ? kpg_pkg::CRC_INIT : crc_r;
   assign stage[0] = base;

   genvar i;
   for (i = 0; i < 8; i++) begin : g_bit
      assign stage[i+1] = (stage[i][0] ^ crc_if.data[i]) ?
         ((stage[i] >> 1) ^ kpg_pkg::CRC_POLY) : (stage[i] >> 1);
   end

   always_comb begin
      crc_if.crc_nxt = crc_if.feed ? stage[8] : base;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_r <= kpg_pkg::CRC_INIT;
      end else if (ce_i) begin
         crc_r <= crc_if.crc_nxt;
      end
   end

   assign crc_if.crc = crc_r;
endmodule // kpg_crc16

// File: kpg_core.sv
`timescale 1ns/1ps
module kpg_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Byte link
   input wire logic bus_reset_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_byte_o,
   // Device status
   input wire logic disabled_i,
   input wire logic pub_wp_i,
   input wire logic priv_wp_i,
   input wire logic priv_guard_i,
   // Curve engine
   output logic ecc_start_o,
   output logic ecc_use_fingerprint_o,
   input wire logic ecc_done_i,
   input wire logic ecc_ok_i,
   // Key memory commits
   output logic wr_pub_o,
   output logic wr_priv_o,
   output logic set_guard_o,
   output logic set_wp_o,
   output logic busy_o
);
   kpg_pkg::kpg_state_t state_r, state_nxt;
   logic [7:0] param_r, param_nxt, tx_byte_r, tx_byte_nxt, result_r, result_nxt;
   logic [kpg_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic pend_r, pend_nxt, start_r, start_nxt;
   logic [3:0] commit_r, commit_nxt;
   logic rx, tx_go, lock_sel, src_fp;

   kpg_crc_if crc_if ();
   kpg_crc16 i_kpg_crc16 (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .crc_if(crc_if));

   assign rx = rx_valid_i;
   assign tx_go = tx_valid_o && tx_ready_i;
   assign lock_sel = param_r[kpg_pkg::LOCK_MSB] ^ param_r[kpg_pkg::LOCK_LSB];
   assign src_fp = param_r[kpg_pkg::SRC_BIT];

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      param_nxt = param_r;
      tx_byte_nxt = tx_byte_r;
      result_nxt = result_r;
      cnt_nxt = cnt_r;
      pend_nxt = pend_r;
      start_nxt = 1'b0;
      commit_nxt = 4'h0;
      crc_if.clr = 1'b0;
      crc_if.feed = 1'b0;
      crc_if.data = rx_byte_i;
      case (state_r)
         kpg_pkg::ST_IDLE: begin
            if (rx && rx_byte_i == kpg_pkg::CMD_START) begin
               crc_if.clr = 1'b1;
               crc_if.feed = 1'b1;
               state_nxt = kpg_pkg::ST_LEN;
            end
         end
         kpg_pkg::ST_LEN: begin
            if (rx) begin
               crc_if.feed = 1'b1;
               state_nxt = (rx_byte_i == kpg_pkg::LEN_CMD) ? kpg_pkg::ST_OPC : kpg_pkg::ST_IDLE;
            end
         end
         kpg_pkg::ST_OPC: begin
            if (rx) begin
               crc_if.feed = 1'b1;
               state_nxt = (rx_byte_i == kpg_pkg::OPC_KEYGEN) ? kpg_pkg::ST_PAR : kpg_pkg::ST_IDLE;
            end
         end
         kpg_pkg::ST_PAR: begin
            if (rx) begin
               crc_if.feed = 1'b1;
               param_nxt = rx_byte_i;
               tx_byte_nxt = ~crc_if.crc_nxt[7:0];
               state_nxt = kpg_pkg::ST_CRC0;
            end
         end
         kpg_pkg::ST_CRC0: begin
            if (tx_go) begin
               tx_byte_nxt = ~crc_if.crc[15:8];
               state_nxt = kpg_pkg::ST_CRC1;
            end
         end
         kpg_pkg::ST_CRC1: begin
            if (tx_go) begin
               state_nxt = kpg_pkg::ST_REL;
            end
         end
         kpg_pkg::ST_REL: begin
            if (rx) begin
               state_nxt = kpg_pkg::ST_IDLE;
               if (rx_byte_i == kpg_pkg::RELEASE_BYTE) begin
                  state_nxt = kpg_pkg::ST_WAIT;
                  cnt_nxt = lock_sel ? kpg_pkg::KGEN_CYC + kpg_pkg::WR_CYC : kpg_pkg::KGEN_CYC;
                  if (disabled_i) begin
                     result_nxt = kpg_pkg::RES_DISABLED;
                  end else if (pub_wp_i || priv_wp_i || (priv_guard_i && !src_fp)) begin
                     result_nxt = kpg_pkg::RES_LOCKED;
                  end else begin
                     pend_nxt = 1'b1;
                     start_nxt = 1'b1;
                  end
               end
            end
         end
         kpg_pkg::ST_WAIT: begin
            if (cnt_r != kpg_pkg::CNT_RST) begin
               cnt_nxt = cnt_r - 12'h001;
            end
            if (pend_r && ecc_done_i) begin
               pend_nxt = 1'b0;
               result_nxt = ecc_ok_i ? kpg_pkg::RES_OK : kpg_pkg::RES_BAD_ECC;
               if (ecc_ok_i) begin
                  commit_nxt = {lock_sel, src_fp, !src_fp, 1'b1};
               end
            end else if (!pend_r && cnt_r == kpg_pkg::CNT_RST) begin
               tx_byte_nxt = kpg_pkg::DUMMY_BYTE;
               state_nxt = kpg_pkg::ST_DUM;
            end
         end
         kpg_pkg::ST_DUM: begin
            if (tx_go) begin
               tx_byte_nxt = kpg_pkg::LEN_RESP;
               state_nxt = kpg_pkg::ST_RLEN;
            end
         end
         kpg_pkg::ST_RLEN: begin
            if (tx_go) begin
               crc_if.clr = 1'b1;
               crc_if.feed = 1'b1;
               crc_if.data = tx_byte_r;
               tx_byte_nxt = result_r;
               state_nxt = kpg_pkg::ST_RES;
            end
         end
         kpg_pkg::ST_RES: begin
            if (tx_go) begin
               crc_if.feed = 1'b1;
               crc_if.data = tx_byte_r;
               tx_byte_nxt = ~crc_if.crc_nxt[7:0];
               state_nxt = kpg_pkg::ST_RCRC0;
            end
         end
         kpg_pkg::ST_RCRC0: begin
            if (tx_go) begin
               tx_byte_nxt = ~crc_if.crc[15:8];
               state_nxt = kpg_pkg::ST_RCRC1;
            end
         end
         kpg_pkg::ST_RCRC1: begin
            if (tx_go) begin
               state_nxt = kpg_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = kpg_pkg::ST_IDLE;
         end
      endcase
      // A bus reset abandons the frame, but a running engine finishes so commits are not lost.
      // reset ends transaction except in ST_WAIT
      if (bus_reset_i && state_r != kpg_pkg::ST_WAIT) begin
         state_nxt = kpg_pkg::ST_IDLE;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= kpg_pkg::ST_IDLE;
         param_r <= kpg_pkg::PARAM_RST;
         tx_byte_r <= kpg_pkg::DUMMY_BYTE;
         result_r <= kpg_pkg::RES_OK;
         cnt_r <= kpg_pkg::CNT_RST;
         pend_r <= 1'b0;
         start_r <= 1'b0;
         commit_r <= 4'h0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         param_r <= param_nxt;
         tx_byte_r <= tx_byte_nxt;
         result_r <= result_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
         start_r <= start_nxt;
         commit_r <= commit_nxt;
      end
   end
   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign tx_valid_o = ce_i && (state_r inside {kpg_pkg::ST_CRC0, kpg_pkg::ST_CRC1,
      kpg_pkg::ST_DUM, kpg_pkg::ST_RLEN, kpg_pkg::ST_RES, kpg_pkg::ST_RCRC0, kpg_pkg::ST_RCRC1});
   assign tx_byte_o = tx_byte_r;
   assign ecc_start_o = start_r;
   assign ecc_use_fingerprint_o = src_fp;
   assign {set_wp_o, set_guard_o, wr_priv_o, wr_pub_o} = commit_r;
   assign busy_o = state_r == kpg_pkg::ST_WAIT;
   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_bad_opcode;
      (ce_i && !bus_reset_i && state_r == kpg_pkg::ST_OPC && rx_valid_i &&
       rx_byte_i != kpg_pkg::OPC_KEYGEN) |=> state_r == kpg_pkg::ST_IDLE;
   endproperty
   a_bad_opcode: assert property (p_bad_opcode) else $error("bad opcode not dropped");
   property p_req_crc;
      (ce_i && state_r == kpg_pkg::ST_PAR && rx_valid_i && !bus_reset_i) |=>
         tx_byte_o == ~crc_if.crc[7:0] && state_r == kpg_pkg::ST_CRC0;
   endproperty
   a_req_crc: assert property (p_req_crc) else $error("request crc wrong");
   property p_delay;
      (ce_i && state_r == kpg_pkg::ST_REL && rx_valid_i && rx_byte_i == kpg_pkg::RELEASE_BYTE)
         |=> cnt_r == (lock_sel ? kpg_pkg::KGEN_CYC + kpg_pkg::WR_CYC : kpg_pkg::KGEN_CYC);
   endproperty
   a_delay: assert property (p_delay) else $error("delay count wrong");
   property p_resp_len;
      (state_r == kpg_pkg::ST_DUM && tx_go && ce_i && !bus_reset_i) |=>
         tx_byte_o == kpg_pkg::LEN_RESP && tx_valid_o == ce_i;
   endproperty
   a_resp_len: assert property (p_resp_len) else $error("response length wrong");
   property p_no_early;
      (state_r == kpg_pkg::ST_DUM) |-> cnt_r == kpg_pkg::CNT_RST && !pend_r;
   endproperty
   a_no_early: assert property (p_no_early) else $error("reply before delay");
   property p_locked;
      (ce_i && state_r == kpg_pkg::ST_REL && rx_valid_i && !disabled_i &&
       rx_byte_i == kpg_pkg::RELEASE_BYTE && (pub_wp_i || priv_wp_i)) |=>
         !ecc_start_o && result_r == kpg_pkg::RES_LOCKED;
   endproperty
   a_locked: assert property (p_locked) else $error("locked key not refused");
   property p_disabled;
      (ce_i && state_r == kpg_pkg::ST_REL && rx_valid_i && disabled_i &&
       rx_byte_i == kpg_pkg::RELEASE_BYTE) |=> result_r == kpg_pkg::RES_DISABLED;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled code wrong");
   property p_priv_write;
      wr_priv_o |-> wr_pub_o && !param_r[kpg_pkg::SRC_BIT];
   endproperty
   a_priv_write: assert property (p_priv_write) else $error("private write misused");
   property p_lock_pages;
      set_wp_o |-> wr_pub_o && (param_r[7] != param_r[6]);
   endproperty
   a_lock_pages: assert property (p_lock_pages) else $error("lock without choice");
   property p_guard;
      set_guard_o |-> param_r[kpg_pkg::SRC_BIT] && result_r == kpg_pkg::RES_OK;
   endproperty
   a_guard: assert property (p_guard) else $error("guard without fingerprint");
endmodule // kpg_core

// File: kpg_host.sv
`timescale 1ns/1ps
module kpg_host (
   // Clock
   input wire logic clk_i,
   // Device bytes
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_byte_i,
   // Host bytes
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   output logic tx_ready_o,
   output logic bus_reset_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_byte_o = 8'h00;
      tx_ready_o = 1'b0;
      bus_reset_o = 1'b0;
   end

   // Framed byte send.
   // The byte line shows the inverse once the strobe drops, so stale data never matches.
   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_byte_o = b;
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b0;
      rx_byte_o = ~b;
   endtask

   // Wait for reply.
   // Polling ends once the device offers a byte or after 2000 cycles, with ok left low on the timeout.
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      b = 8'h00;
      @(posedge clk_i);
      #1;
      tx_ready_o = 1'b1;
      while (!ok && n < 2000) begin
         @(posedge clk_i);
         if (tx_valid_i === 1'b1) begin
            ok = 1'b1;
            b = tx_byte_i;
         end
         n++;
      end
      #1;
      tx_ready_o = 1'b0;
   endtask

   task automatic bus_rst();
      @(posedge clk_i);
      #1;
      bus_reset_o = 1'b1;
      @(posedge clk_i);
      #1;
      bus_reset_o = 1'b0;
   endtask
endmodule // kpg_host

// File: key_pair_generate_command_tb.sv
`timescale 1ns/1ps
module key_pair_generate_command_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic rx_valid, tx_ready, tx_valid, bus_reset, ecc_start, ecc_fp, ecc_ok = 1'b1;
   logic [7:0] rx_byte, tx_byte;
   logic dis = 1'b0, pwp = 1'b0, vwp = 1'b0, grd = 1'b0, ce = 1'b1;
   logic wr_pub, wr_priv, set_guard, set_wp, busy;
   logic s_pub, s_priv, s_guard, s_wp, s_start, s_fp;
   int eng_cnt = 0, busy_cnt = 0, fail_count = 0, total_checks = 0;

   always #2 clk_i = ~clk_i;

   kpg_core i_kpg_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus_reset_i(bus_reset),
      .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
      .tx_byte_o(tx_byte), .disabled_i(dis), .pub_wp_i(pwp), .priv_wp_i(vwp),
      .priv_guard_i(grd), .ecc_start_o(ecc_start), .ecc_use_fingerprint_o(ecc_fp),
      .ecc_done_i(eng_cnt == 1), .ecc_ok_i(ecc_ok), .wr_pub_o(wr_pub), .wr_priv_o(wr_priv),
      .set_guard_o(set_guard), .set_wp_o(set_wp), .busy_o(busy));

   kpg_host i_kpg_host (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
      .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_ready_o(tx_ready),
      .bus_reset_o(bus_reset));

   // ****************************************************************
   // Curve engine stand-in and commit monitor
   // ****************************************************************
   always @(posedge clk_i) begin
      eng_cnt <= (ecc_start === 1'b1) ? 5 : (eng_cnt != 0 ? eng_cnt - 1 : 0);
      if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
      if (wr_pub === 1'b1) s_pub <= 1'b1;
      if (wr_priv === 1'b1) s_priv <= 1'b1;
      if (set_guard === 1'b1) s_guard <= 1'b1;
      if (set_wp === 1'b1) s_wp <= 1'b1;
      if (ecc_start === 1'b1) begin
         s_start <= 1'b1;
         s_fp <= ecc_fp;
      end
   end

   // ****************************************************************
   // Compare and closing
   // ****************************************************************
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
      return r;
   endfunction

   // One full transaction; st is disabled, public protect, private protect, guard.
   task automatic run(input logic [7:0] par, input logic [3:0] st, input logic ok,
                      input logic [7:0] res);
      logic [15:0] c;
      logic [7:0] b;
      logic got, lock, go;
      int e;
      lock = par[7] ^ par[6];
      go = (res == kpg_pkg::RES_OK) || (res == kpg_pkg::RES_BAD_ECC);
      e = lock ? int'(kpg_pkg::KGEN_CYC) + int'(kpg_pkg::WR_CYC) : int'(kpg_pkg::KGEN_CYC);
      {dis, pwp, vwp, grd} = st;
      ecc_ok = ok;
      {s_pub, s_priv, s_guard, s_wp, s_start, s_fp} = 6'h00;
      busy_cnt = 0;
      c = crc_upd(crc_upd(crc_upd(crc_upd(16'h0000, 8'h66), 8'h02), 8'hCB), par);
      i_kpg_host.send(kpg_pkg::CMD_START);
      i_kpg_host.send(kpg_pkg::LEN_CMD);
      i_kpg_host.send(kpg_pkg::OPC_KEYGEN);
      i_kpg_host.send(par);
      i_kpg_host.recv(b, got);
      check8("req crc lo", ~c[7:0], b);
      i_kpg_host.recv(b, got);
      check8("req crc hi", ~c[15:8], b);
      i_kpg_host.send(kpg_pkg::RELEASE_BYTE);
      repeat (e) @(posedge clk_i);
      i_kpg_host.recv(b, got);
      check8("dummy", 8'hFF, b);
      c = crc_upd(crc_upd(16'h0000, 8'h01), res);
      i_kpg_host.recv(b, got);
      check8("resp len", 8'h01, b);
      i_kpg_host.recv(b, got);
      check8("result", res, b);
      i_kpg_host.recv(b, got);
      check8("resp crc lo", ~c[7:0], b);
      i_kpg_host.recv(b, got);
      check8("resp crc hi", ~c[15:8], b);
      check1("reply offered", 1'b1, got);
      check1("engine start", go, s_start);
      check1("busy span", 1'b1, busy_cnt >= e && busy_cnt <= e + 3);
      if (go) check1("fingerprint", par[0], s_fp);
      check1("write pub", res == 8'hAA, s_pub);
      check1("write priv", res == 8'hAA && !par[0], s_priv);
      check1("set guard", res == 8'hAA && par[0], s_guard);
      check1("set wp", res == 8'hAA && lock, s_wp);
      i_kpg_host.bus_rst();
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_plain();
      run(8'h00, 4'h0, 1'b1, 8'hAA);
      run(8'hC0, 4'h0, 1'b1, 8'hAA);
   endtask

   task automatic t_lock_once();
      run(8'h41, 4'h0, 1'b1, 8'hAA);
      run(8'h80, 4'h6, 1'b1, 8'h55);
   endtask

   task automatic t_codes();
      logic [7:0] par [5] = '{8'h01, 8'h00, 8'h00, 8'h81, 8'hC1};
      logic [3:0] st [5] = '{4'hE, 4'h2, 4'h1, 4'h1, 4'h0};
      logic okv [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      logic [7:0] res [5] = '{8'h88, 8'h55, 8'h55, 8'hAA, 8'h22};
      for (int i = 0; i < 5; i++) run(par[i], st[i], okv[i], res[i]);
   endtask

   task automatic t_bad_opcode();
      i_kpg_host.send(8'h66);
      i_kpg_host.send(8'h02);
      i_kpg_host.send(8'hCD);
      i_kpg_host.send(8'h00);
      repeat (10) @(posedge clk_i);
      #1;
      check1("no answer", 1'b0, tx_valid);
      run(8'h00, 4'h0, 1'b1, 8'hAA);
   endtask

   // Bytes offered while the clock enable is low must leave no trace in the frame decoder.
   task automatic t_freeze();
      ce = 1'b0;
      i_kpg_host.send(kpg_pkg::CMD_START);
      i_kpg_host.send(kpg_pkg::LEN_CMD);
      ce = 1'b1;
      run(8'h40, 4'h0, 1'b1, 8'hAA);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      t_plain();
      t_lock_once();
      t_codes();
      t_bad_opcode();
      t_freeze();
      complete_run();
   end

   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
endmodule // key_pair_generate_command_tb
